// ===== core/pwg_pkg.sv
// Constants for the peripheral write-protection controller
package pwg_pkg;
   localparam int unsigned PWG_DATA_W = 32;
   localparam int unsigned PWG_ADDR_W = 8;
   localparam logic [7:0] PWG_OFF_CLR = 8'h00;
   localparam logic [7:0] PWG_OFF_SET = 8'h04;
   localparam logic [31:0] PWG_PROT_RESET = 32'h0000_0000;
   // Implemented protect bits of the first instance: bits 6..1
   localparam logic [31:0] PWG_IMPL_MASK0 = 32'h0000_007e;
   localparam int unsigned PWG_BIT_POWER_MANAGER = 1;
   localparam int unsigned PWG_BIT_SYSTEM_CONTROL = 2;
   localparam int unsigned PWG_BIT_GENERIC_CLOCK = 3;
   localparam int unsigned PWG_BIT_WATCHDOG = 4;
   localparam int unsigned PWG_BIT_RTC = 5;
   localparam int unsigned PWG_BIT_EXT_IRQ_CTRL = 6;
   // Instances whose bus clock runs out of reset
   localparam int unsigned PWG_CLK_ON_INSTANCES = 2;
   typedef enum logic [1:0] {
      PWG_RESP_OK = 2'b00,
      PWG_RESP_ERR = 2'b01
   } pwg_resp_type;
endpackage : pwg_pkg

// ===== core/pwg_periph_access_guard.sv
// Peripheral write-protection controller for one peripheral bridge
// Operation
// - One controller per bridge guards writes to every peripheral on it.
// - Bus clock on at reset for instances 0 and 1, off for instance 2.
// - Keeps working in any sleep mode while its clock runs.
// - Debugger writes bypass write protection entirely.
// - Writing one in clear view clears protect bit in both views.
// - Writing one in set view sets protect bit in both views.
// - Both views read back the same protect vector.
// - Write to protected peripheral is dropped and answered with an error.
// - Setting an already set protect bit answers an error.
// - Clearing an already clear protect bit answers an error.
// - Zero bits written leave protection unchanged.
// - Byte, halfword and word accesses, with lanes selected by the strobes at the word offsets 0x00 and 0x04 only.
// - First instance bits 6..1 guard irq, rtc, watchdog, clock, system control, power.
module pwg_periph_access_guard
   import pwg_pkg::*;
#(
   parameter int unsigned INSTANCE = 0,
   parameter logic [31:0] IMPL_MASK = PWG_IMPL_MASK0,
   parameter int unsigned IDX_W = 5
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Power manager control of the guard bus clock
   input wire logic i_bus_clk_on,
   input wire logic i_bus_clk_off,
   output logic o_guard_bus_clock_q,
   // Peripheral bus register port
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [PWG_ADDR_W-1:0] i_paddr,
   input wire logic [PWG_DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [PWG_DATA_W-1:0] o_prdata_q,
   output logic o_pready_q,
   output logic o_pslverr_q,
   // Guarded peripheral write check
   input wire logic i_pw_valid,
   input wire logic [IDX_W-1:0] i_pw_index,
   input wire logic i_pw_debug,
   output logic o_pw_allow_q,
   output logic o_pw_err_q,
   // Protect vector
   output logic [PWG_DATA_W-1:0] o_protect_q
);
   // Third instance starts gated until the power manager opens it
   localparam logic CLK_RESET = (INSTANCE < PWG_CLK_ON_INSTANCES) ? 1'b1 : 1'b0;

   // Stored vector and decode wires
   logic [PWG_DATA_W-1:0] prot_q;
   logic [PWG_DATA_W-1:0] prot_d;
   logic [PWG_DATA_W-1:0] rdata_d;
   logic [PWG_DATA_W-1:0] lane_mask;
   logic [PWG_DATA_W-1:0] wmask;
   logic clk_on_q;
   logic setup;
   logic hit_clr;
   logic hit_set;
   logic wr_clr;
   logic wr_set;
   logic dbl_err;
   logic unmapped;
   logic err_d;
   logic blocked;
   logic rd_view;

   // Request decode; no answer while the bus clock is gated off
   assign setup = i_psel & ~i_penable & ~o_pready_q & clk_on_q;
   assign hit_clr = (i_paddr == PWG_OFF_CLR);
   assign hit_set = (i_paddr == PWG_OFF_SET);
   assign unmapped = setup & ~hit_clr & ~hit_set;
   // Byte lanes allow 8-, 16- and 32-bit writes
   assign lane_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
   assign wmask = i_pwdata & lane_mask & IMPL_MASK;
   // Writes act only in the setup cycle, so each transfer counts once
   assign wr_clr = setup & i_pwrite & hit_clr;
   assign wr_set = setup & i_pwrite & hit_set;

   // Double protect or unprotect is a program-flow fault
   assign dbl_err = (wr_set & |(wmask & prot_q)) |
                    (wr_clr & |(wmask & ~prot_q));
   // Unmapped offsets answer an error and change nothing
   assign err_d = dbl_err | unmapped;

   // Set and clear views act on the one stored vector
   assign prot_d = wr_set ? (prot_q | wmask) :
                   wr_clr ? (prot_q & ~wmask) :
                   prot_q;
   // Both views read the same vector
   assign rd_view = setup & ~i_pwrite & (hit_clr | hit_set);
   assign rdata_d = rd_view ? prot_q : '0;

   // Debugger bypasses the check; protected writes are refused
   // A change and a check in one cycle: the check sees the old vector
   assign blocked = i_pw_valid & ~i_pw_debug & prot_q[i_pw_index];

   // Protect bits of every peripheral on this bridge
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         prot_q <= PWG_PROT_RESET & IMPL_MASK;
      end
      else
      begin
         prot_q <= prot_d;
      end
   end

   // Bus clock gate, reset value depends on the instance
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         clk_on_q <= CLK_RESET;
      end
      else if (i_bus_clk_on)
      begin
         clk_on_q <= 1'b1;
      end
      else if (i_bus_clk_off)
      begin
         clk_on_q <= 1'b0;
      end
   end

   // Bus answer, registered into the access cycle
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pready_q <= 1'b0;
         o_pslverr_q <= 1'b0;
         o_prdata_q <= '0;
      end
      else
      begin
         o_pready_q <= setup;
         o_pslverr_q <= err_d;
         o_prdata_q <= rdata_d;
      end
   end

   // Peripheral check needs no sleep gating: it runs with the clock
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pw_allow_q <= 1'b0;
         o_pw_err_q <= 1'b0;
      end
      else
      begin
         o_pw_allow_q <= i_pw_valid & ~blocked;
         o_pw_err_q <= blocked;
      end
   end

   // Outputs come straight from their flops
   assign o_guard_bus_clock_q = clk_on_q;
   assign o_protect_q = prot_q;

   // All checks run on the one clock and rest during reset
   default clocking dc @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   // Register views
   set_view_a: assert property (wr_set |=> ((prot_q & $past(wmask)) == $past(wmask)))
      else $error("set view write did not set bits");
   clr_view_a: assert property (wr_clr |=> ((prot_q & $past(wmask)) == '0))
      else $error("clear view write did not clear bits");
   zero_keep_a: assert property ((wr_set | wr_clr) |=>
      ((prot_q & ~$past(wmask)) == ($past(prot_q) & ~$past(wmask))))
      else $error("zero bits changed protection");
   prot_hold_a: assert property (~(wr_set | wr_clr) |=> $stable(prot_q))
      else $error("protect vector changed without a write");
   same_read_a: assert property ((setup & ~i_pwrite & (hit_clr | hit_set)) |=>
      (o_prdata_q == $past(prot_q)))
      else $error("view readback differs from protect vector");

   // Error responses
   double_set_a: assert property ((wr_set & |(wmask & prot_q)) |=> (o_pready_q & o_pslverr_q))
      else $error("double protect not flagged");
   double_clr_a: assert property ((wr_clr & |(wmask & ~prot_q)) |=> (o_pready_q & o_pslverr_q))
      else $error("double unprotect not flagged");
   unmapped_err_a: assert property (unmapped |=> (o_pready_q & o_pslverr_q))
      else $error("unmapped access not flagged");
   ready_pulse_a: assert property (o_pready_q |=> ~o_pready_q)
      else $error("ready held past one cycle");
   err_ready_a: assert property (o_pslverr_q |-> o_pready_q)
      else $error("error shown outside the access cycle");

   // Peripheral write check
   blocked_write_a: assert property ((i_pw_valid & ~i_pw_debug & prot_q[i_pw_index]) |=>
      (o_pw_err_q & ~o_pw_allow_q))
      else $error("protected write not refused");
   debug_pass_a: assert property ((i_pw_valid & i_pw_debug) |=> (o_pw_allow_q & ~o_pw_err_q))
      else $error("debugger write was blocked");
   open_pass_a: assert property ((i_pw_valid & ~prot_q[i_pw_index]) |=> (o_pw_allow_q & ~o_pw_err_q))
      else $error("open peripheral write refused");
   pw_excl_a: assert property (~(o_pw_allow_q & o_pw_err_q))
      else $error("write both allowed and refused");

   // Clock gate and unused bits
   clk_off_a: assert property (~clk_on_q |=> ~o_pready_q)
      else $error("answer given with bus clock off");
   clk_set_a: assert property (i_bus_clk_on |=> clk_on_q)
      else $error("bus clock not enabled on request");
   unimpl_bits_a: assert property ((prot_q & ~IMPL_MASK) == '0)
      else $error("unimplemented protect bit set");

   // Main scenarios
   protect_c: cover property (wr_set ##1 wr_clr);
   double_c: cover property (dbl_err);
   block_c: cover property (blocked);
   debug_c: cover property (i_pw_valid & i_pw_debug & prot_q[i_pw_index]);
   gated_c: cover property (i_psel & ~clk_on_q);
endmodule // pwg_periph_access_guard

// ===== verification/pwg_periph_master.sv
// Peripheral-side model issuing guarded write attempts
module pwg_periph_master
(
   input wire logic i_sys_clk,
   input wire logic i_allow,
   input wire logic i_err,
   output logic o_valid,
   output logic [4:0] o_index,
   output logic o_debug
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {o_valid, o_index, o_debug} = '0;
   // One-cycle attempt; index inverted on release so a stale value never looks valid
   task automatic attempt(input logic [4:0] idx, input logic dbg, output logic [1:0] res);
      @(posedge i_sys_clk);
      {o_valid, o_index, o_debug} <= {1'b1, idx, dbg};
      @(posedge i_sys_clk);
      {o_valid, o_index} <= {1'b0, ~idx};
      // Answer stands one cycle; it is taken at the edge that ends it
      @(posedge i_sys_clk);
      res = {i_allow, i_err};
   endtask
endmodule // pwg_periph_master

// ===== verification/pwg_periph_access_guard_tb.sv
// Self-checking bench for the peripheral write-protection controller
module pwg_periph_access_guard_tb import pwg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, bc_on = 0, bc_off = 0, psel = 0, pen = 0, pwr = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, rd, prdata, prot;
   logic [3:0] pstrb = '0;
   logic bclk, pready, pslverr, pv, pdbg, allow, perr, e;
   logic [1:0] r;
   logic [4:0] pidx;
   int err_count = 0, check_count = 0;
   always #50 clk = ~clk;
   pwg_periph_access_guard DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_bus_clk_on(bc_on), .i_bus_clk_off(bc_off),
      .o_guard_bus_clock_q(bclk), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata_q(prdata), .o_pready_q(pready), .o_pslverr_q(pslverr),
      .i_pw_valid(pv), .i_pw_index(pidx), .i_pw_debug(pdbg), .o_pw_allow_q(allow), .o_pw_err_q(perr),
      .o_protect_q(prot));
   pwg_periph_master p (.i_sys_clk(clk), .i_allow(allow), .i_err(perr), .o_valid(pv), .o_index(pidx),
      .o_debug(pdbg));
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Setup then access; bounded wait so a silent port cannot hang the run
   task automatic apb(logic w, logic [7:0] ad, logic [31:0] d, logic [3:0] s = 4'hf, logic live = 1'b1);
      int n = 0;
      @(posedge clk);
      {psel, pwr, paddr, pwdata, pstrb} <= {1'b1, w, ad, d, s};
      @(posedge clk);
      pen <= 1'b1;
      // Answer is taken at the edge that samples ready high
      do @(posedge clk); while (pready !== 1'b1 && ++n < 8);
      {rd, e} = {prdata, pslverr};
      chk("answer", pready === 1'b1, live);
      {psel, pen, pwdata} <= {2'b00, ~d};
   endtask
   task automatic t_set;
      chk("bus clock", bclk, 1);
      apb(0, PWG_OFF_CLR, 0);
      chk("reset view", rd, PWG_PROT_RESET);
      apb(1, PWG_OFF_SET, 32'h10);
      chk("set err", e, 0);
      chk("set", prot, 32'h10);
      apb(0, PWG_OFF_CLR, 0);
      chk("clear view", rd, 32'h10);
      apb(1, PWG_OFF_SET, 32'h10);
      chk("double set", e, 1);
      $display("set test done");
   endtask
   task automatic t_guard;
      p.attempt(5'd4, 0, r);
      chk("blocked", r, 2'b01);
      p.attempt(5'd4, 1, r);
      chk("debugger", r, 2'b10);
      p.attempt(5'd5, 0, r);
      chk("open", r, 2'b10);
      $display("guard test done");
   endtask
   task automatic t_clr;
      apb(1, PWG_OFF_CLR, 32'h10);
      chk("clear", prot, 0);
      apb(1, PWG_OFF_CLR, 32'h10);
      chk("double clear", e, 1);
      apb(1, PWG_OFF_SET, 32'h7e, 4'he);
      chk("masked lane", prot, 0);
      apb(1, PWG_OFF_SET, 32'hff);
      apb(0, PWG_OFF_SET, 0);
      chk("set view", rd, PWG_IMPL_MASK0);
      apb(1, PWG_OFF_CLR, 0);
      chk("zero write", prot, PWG_IMPL_MASK0);
      // Unprotect only what the set view shows as protected
      apb(0, PWG_OFF_SET, 0);
      apb(1, PWG_OFF_CLR, rd & ((32'h1 << PWG_BIT_WATCHDOG) | (32'h1 << PWG_BIT_RTC)));
      chk("guarded clear", e, 0);
      chk("two cleared", prot, 32'h4e);
      apb(0, 8'h08, 0);
      chk("unmapped", e, 1);
      $display("clear test done");
   endtask
   task automatic t_clock;
      @(posedge clk) bc_off <= 1'b1;
      @(posedge clk) bc_off <= 1'b0;
      @(negedge clk) chk("clock off", bclk, 0);
      apb(1, PWG_OFF_SET, 32'h30, 4'hf, 1'b0);
      chk("gated write", prot, 32'h4e);
      @(posedge clk) bc_on <= 1'b1;
      @(posedge clk) bc_on <= 1'b0;
      @(negedge clk) chk("clock on", bclk, 1);
      apb(0, PWG_OFF_CLR, 0);
      chk("awake view", rd, 32'h4e);
      // Mid-run reset brings back the clock and an open vector
      @(posedge clk) bc_off <= 1'b1;
      @(posedge clk) bc_off <= 1'b0;
      @(posedge clk) rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk) chk("reset clock", bclk, 1);
      chk("reset vector", prot, PWG_PROT_RESET);
      $display("clock test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_set;
      t_guard;
      t_clr;
      t_clock;
      wrap_up;
   end
   // Watchdog well past the fewer than one hundred cycles the tests need
   initial
   begin
      #100000;
      err_count++;
      wrap_up;
   end
endmodule // pwg_periph_access_guard_tb
